// File: rtcpi_pkg.sv
// constants, register map and timing for the rtc port interface
// Function
// [RQ1] raise an interrupt every second after power-up; tick status sets every second but irq needs mask bit 0, which resets to 0
// [RQ2] time keeps running even when ticks are missed
// [RQ3] registers hold two BCD digits, tens high
// [RQ4] host reads: select, setup bit, read strobe
// [RQ5] read strobe held 1 us, register driven
// [RQ6] host writes: select masked, data two below
// [RQ7] write strobe held 1 us latches the data
// [RQ8] host reads time at power-up
// [RQ9] host never overlaps strobes, keeps selection stable
package rtcpi_pkg;
    // clock and strobe timing
    localparam int unsigned CLK_HZ     = 40_000_000;
    localparam int unsigned CLK_NS     = 25;
    localparam int unsigned STROBE_NS  = 1000;
    localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned HOLD_W     = 6;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL   = 8'h5c;
    localparam logic [7:0]  IDX_DATA   = 8'h5a;
    localparam logic [7:0]  IDX_STAT   = 8'h60;
    localparam logic [7:0]  IDX_MASK   = 8'h61;
    localparam logic [9:0]  ADDR_CTRL  = {IDX_CTRL, 2'b00};
    localparam logic [9:0]  ADDR_DATA  = {IDX_DATA, 2'b00};
    localparam logic [9:0]  ADDR_STAT  = {IDX_STAT, 2'b00};
    localparam logic [9:0]  ADDR_MASK  = {IDX_MASK, 2'b00};
    // control port fields
    localparam int unsigned CTRL_SETUP = 7;
    localparam int unsigned CTRL_WR    = 6;
    localparam int unsigned CTRL_RD    = 5;
    localparam int unsigned SEL_W      = 5;
    // clock register numbers
    localparam int unsigned NREG       = 8;
    localparam int unsigned REG_SEC    = 2;
    localparam int unsigned REG_MIN    = 3;
    localparam int unsigned REG_HOUR   = 4;
    localparam int unsigned REG_DAY    = 5;
    localparam int unsigned REG_MON    = 6;
    localparam int unsigned REG_YEAR   = 7;
    localparam logic [7:0]  CLK_RST [NREG] =
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    // BCD limits
    localparam logic [7:0]  BCD_SEC_MAX  = 8'h59;
    localparam logic [7:0]  BCD_HOUR_MAX = 8'h23;
    localparam logic [7:0]  BCD_MON_MAX  = 8'h12;
    localparam logic [7:0]  BCD_YEAR_MAX = 8'h99;
    localparam logic [7:0]  BCD_ONE      = 8'h01;
    // interrupt status bits
    localparam int unsigned IRQ_W      = 2;
    localparam int unsigned IRQ_TICK   = 0;
    localparam int unsigned IRQ_WDONE  = 1;
endpackage : rtcpi_pkg

// File: rtcpi_top.sv
// rtc port interface: control and data ports, bcd clock, avalon slave
`timescale 1ns/100ps
module rtcpi_top
#(
    parameter int unsigned TICK_CYCLES = rtcpi_pkg::CLK_HZ
)
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq
);
    import rtcpi_pkg::*;

    logic [7:0]        clk_reg   [NREG];
    logic [7:0]        next_time [NREG];
    logic [7:0]        ctrl;
    logic [7:0]        data_port;
    logic [IRQ_W-1:0]  stat;
    logic [IRQ_W-1:0]  mask;
    logic [IRQ_W-1:0]  next_stat;
    logic [31:0]       presc;
    logic              tick;
    logic [HOLD_W-1:0] hold_cnt;
    logic              acc_wr;
    logic              acc_rd;
    logic              rd_strobe;
    logic              wr_strobe;
    logic              held;
    logic              wr_fire;
    logic [SEL_W-1:0]  sel;
    logic [7:0]        sel_val;
    logic [31:0]       rd_value;
    logic [7:0]        dim;

    // one wait state per access: the request is seen, then completed
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end

    assign acc_wr = avs_write & ~avs_waitrequest;
    assign acc_rd = avs_read & ~avs_waitrequest;

    // decoded strobes from the control port
    assign sel       = ctrl[SEL_W-1:0];
    assign rd_strobe = ctrl[CTRL_SETUP] & ctrl[CTRL_RD]; // [RQ5]
    assign wr_strobe = ctrl[CTRL_WR];
    assign held      = hold_cnt >= HOLD_W'(STROBE_CYC);

    // a write lands when the strobe drops after a full hold time;
    // a shorter pulse is ignored so glitches cannot corrupt the clock
    assign wr_fire = acc_wr && avs_address == ADDR_CTRL && wr_strobe
                     && !avs_writedata[CTRL_WR] && held; // [RQ7]

    // control and data port registers
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            ctrl      <= 8'h00;
            data_port <= 8'h00;
        end
        else if (acc_wr)
        begin
            if (avs_address == ADDR_CTRL)
                ctrl <= avs_writedata[7:0];
            if (avs_address == ADDR_DATA)
                data_port <= avs_writedata[7:0];
        end
    end

    // strobe hold time counter, cleared only while neither strobe is set, stops at the strobe time
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            hold_cnt <= '0;
        else if (!(rd_strobe | wr_strobe))
            hold_cnt <= '0;
        else if (!held)
            hold_cnt <= hold_cnt + HOLD_W'(1);
    end

    // once-per-second prescaler, free running from reset
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            presc <= '0;
            tick  <= 1'b0;
        end
        else if (presc == 32'(TICK_CYCLES - 1))
        begin
            presc <= '0;
            tick  <= 1'b1; // [RQ1]
        end
        else
        begin
            presc <= presc + 32'h1;
            tick  <= 1'b0;
        end
    end

    // bcd increment of two digits, tens in the upper nibble
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0}; // [RQ3]
        return {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    // last day of the month; leap years are multiples of four
    always_comb
    begin
        case (clk_reg[REG_MON])
            8'h02:
                if (clk_reg[REG_YEAR][4])
                    dim = (clk_reg[REG_YEAR][3:0] == 4'h2 ||
                           clk_reg[REG_YEAR][3:0] == 4'h6) ? 8'h29 : 8'h28;
                else
                    dim = (clk_reg[REG_YEAR][3:0] == 4'h0 ||
                           clk_reg[REG_YEAR][3:0] == 4'h4 ||
                           clk_reg[REG_YEAR][3:0] == 4'h8) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11:
                dim = 8'h30;
            default:
                dim = 8'h31;
        endcase
    end

    // carry chain from seconds to years; counting never depends on
    // the host taking its interrupt
    always_comb
    begin
        for (int i = 0; i < NREG; i++)
            next_time[i] = clk_reg[i];
        if (clk_reg[REG_SEC] != BCD_SEC_MAX)
            next_time[REG_SEC] = bcd_inc(clk_reg[REG_SEC]); // [RQ2]
        else
        begin
            next_time[REG_SEC] = 8'h00;
            if (clk_reg[REG_MIN] != BCD_SEC_MAX)
                next_time[REG_MIN] = bcd_inc(clk_reg[REG_MIN]);
            else
            begin
                next_time[REG_MIN] = 8'h00;
                if (clk_reg[REG_HOUR] != BCD_HOUR_MAX)
                    next_time[REG_HOUR] = bcd_inc(clk_reg[REG_HOUR]);
                else
                begin
                    next_time[REG_HOUR] = 8'h00;
                    if (clk_reg[REG_DAY] < dim)
                        next_time[REG_DAY] = bcd_inc(clk_reg[REG_DAY]);
                    else
                    begin
                        next_time[REG_DAY] = BCD_ONE;
                        if (clk_reg[REG_MON] < BCD_MON_MAX)
                            next_time[REG_MON] = bcd_inc(clk_reg[REG_MON]);
                        else
                        begin
                            next_time[REG_MON] = BCD_ONE;
                            next_time[REG_YEAR] =
                                (clk_reg[REG_YEAR] == BCD_YEAR_MAX) ?
                                8'h00 : bcd_inc(clk_reg[REG_YEAR]);
                        end
                    end
                end
            end
        end
    end

    // clock registers; a host write beats the tick in the same cycle
    for (genvar g = 0; g < NREG; g++)
    begin : g_reg
        always_ff @(posedge ref_clk)
        begin
            if (!resetn)
                clk_reg[g] <= CLK_RST[g];
            else if (wr_fire && sel == SEL_W'(g))
                clk_reg[g] <= data_port; // [RQ7]
            else if (tick)
                clk_reg[g] <= next_time[g]; // [RQ2]
        end
    end

    // selected register value, zero for numbers with no register
    assign sel_val = (sel < SEL_W'(NREG)) ? clk_reg[sel[2:0]] : 8'h00;

    // read mux; the control port shows the register while the read strobe is set
    always_comb
    begin
        case (avs_address)
            ADDR_CTRL:
                rd_value = {24'h0, rd_strobe ? sel_val : ctrl}; // [RQ5]
            ADDR_DATA:
                rd_value = {24'h0, data_port};
            ADDR_STAT:
                rd_value = {{(32-IRQ_W){1'b0}}, stat};
            ADDR_MASK:
                rd_value = {{(32-IRQ_W){1'b0}}, mask};
            default:
                rd_value = 32'h0;
        endcase
    end

    // read data is captured in the wait cycle and stands at completion
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            avs_readdata <= 32'h0;
        else if (avs_read && avs_waitrequest)
            avs_readdata <= rd_value;
    end

    // sticky status: a set in the clearing cycle survives the clear
    always_comb
    begin
        next_stat = stat;
        if (acc_rd && avs_address == ADDR_STAT)
            next_stat = stat & ~avs_readdata[IRQ_W-1:0]; // unreported stay
        if (tick)
            next_stat[IRQ_TICK] = 1'b1; // [RQ1]
        if (wr_fire)
            next_stat[IRQ_WDONE] = 1'b1;
    end

    // status, mask and the level interrupt out of a flip-flop
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            stat <= '0;
            mask <= '0;
            irq  <= 1'b0;
        end
        else
        begin
            stat <= next_stat;
            if (acc_wr && avs_address == ADDR_MASK)
                mask <= avs_writedata[IRQ_W-1:0];
            irq  <= |(next_stat & (acc_wr && avs_address == ADDR_MASK ?
                    avs_writedata[IRQ_W-1:0] : mask)); // [RQ1]
        end
    end

    // checks
    sequence s_rd_held;
        rd_strobe && held;
    endsequence
    sequence s_rd_ctrl;
        avs_read && avs_waitrequest && avs_address == ADDR_CTRL;
    endsequence
    property p_read_drive;
        @(posedge ref_clk) disable iff (!resetn)
        (s_rd_held and s_rd_ctrl) |=> avs_readdata[7:0] == $past(sel_val);
    endproperty
    a_read_drive: assert property (p_read_drive) // [RQ5]
        else $error("strobed read did not return the register");
    a_tick_status: assert property ( // [RQ1]
        @(posedge ref_clk) disable iff (!resetn)
        tick |=> stat[IRQ_TICK] ##1 (irq || !mask[IRQ_TICK]))
        else $error("tick did not set its status bit");
    a_tick_spacing: assert property ( // [RQ1]
        @(posedge ref_clk) disable iff (!resetn)
        tick |=> (!tick) [*8])
        else $error("ticks closer than the prescaler allows");
    a_sec_carry: assert property ( // [RQ2]
        @(posedge ref_clk) disable iff (!resetn)
        tick && !wr_fire && clk_reg[REG_SEC] == BCD_SEC_MAX |=>
        clk_reg[REG_SEC] == 8'h00 &&
        clk_reg[REG_MIN] != $past(clk_reg[REG_MIN]))
        else $error("seconds rollover did not carry");
    a_bcd_digits: assert property ( // [RQ3]
        @(posedge ref_clk) disable iff (!resetn)
        $past(tick) && !$past(wr_fire) |->
        clk_reg[REG_SEC][3:0] <= 4'h9 && clk_reg[REG_SEC][7:4] <= 4'h5)
        else $error("seconds left bcd range");
    a_write_latch: assert property ( // [RQ7]
        @(posedge ref_clk) disable iff (!resetn)
        wr_fire && sel < SEL_W'(NREG) |=>
        clk_reg[$past(sel[2:0])] == $past(data_port) && stat[IRQ_WDONE])
        else $error("write strobe did not latch the data");
    a_short_write: assert property ( // [RQ7]
        @(posedge ref_clk) disable iff (!resetn)
        wr_strobe && hold_cnt < HOLD_W'(STROBE_CYC - 1) |-> !wr_fire)
        else $error("short write strobe was accepted");
    a_wait_once: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not completed after one wait state");

endmodule : rtcpi_top

// File: rtcpi_host_model.sv
// host processor model driving the clock ports over avalon
`timescale 1ns/100ps
module rtcpi_host_model
(
    input  wire logic        ref_clk,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output logic      [9:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata
);
    import rtcpi_pkg::*;
    // idle bus at time zero
    initial
    begin
        avs_address   = 10'h000;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
    end
    // one access, held until waitrequest seen low; ends an edge later;
    // no limit here, the bench watchdog ends a hung access
    task automatic bus(input logic wr, input logic [9:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    // select, data two below, strobe held, release; strobes never overlap
    task automatic reg_write(input logic [4:0] sel, input logic [7:0] v,
                             input int hold);
        logic [31:0] q;
        bus(1'b1, ADDR_CTRL, {27'h0, sel}, q);
        bus(1'b1, ADDR_DATA, {24'h0, v}, q);
        bus(1'b1, ADDR_CTRL, {24'h0, 3'b010, sel}, q);
        repeat (hold) @(posedge ref_clk);
        bus(1'b1, ADDR_CTRL, {27'h0, sel}, q);
    endtask : reg_write
    // setup, read strobe, wait the strobe time, sample, remove strobe
    task automatic reg_read(input logic [4:0] sel, output logic [31:0] v);
        logic [31:0] q;
        bus(1'b1, ADDR_CTRL, {24'h0, 3'b100, sel}, q);
        bus(1'b1, ADDR_CTRL, {24'h0, 3'b101, sel}, q);
        repeat (STROBE_CYC) @(posedge ref_clk);
        bus(1'b0, ADDR_CTRL, 32'h0, v);
        bus(1'b1, ADDR_CTRL, {24'h0, 3'b100, sel}, q);
    endtask : reg_read
endmodule : rtcpi_host_model

// File: rtcpi_tb_top.sv
// self-checking bench for the rtc port interface
`timescale 1ns/100ps
module rtcpi_tb_top;
    import rtcpi_pkg::*;
    // short second so the rollover is reached quickly
    localparam int unsigned TICK = 4000;
    logic        ref_clk;
    logic        resetn;
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic [31:0] rd;
    int          error_cnt;
    int          total_checks;
    int          n;
    // rows: register number and value; the last of the year before rollover
    logic [4:0]  row_sel [8] = '{5'h00, 5'h01, 5'h02, 5'h03,
                                 5'h04, 5'h05, 5'h06, 5'h07};
    logic [7:0]  row_val [8] = '{8'h5a, 8'ha5, 8'h59, 8'h59,
                                 8'h23, 8'h31, 8'h12, 8'h99};

    rtcpi_top #(.TICK_CYCLES(TICK)) rtcpi_top_i
    (
        .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq)
    );
    rtcpi_host_model rtcpi_host_model_i
    (
        .ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata)
    );

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // hang guard, far beyond one tick plus all accesses
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        stop_test();
    end

    initial
    begin
        resetn = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        check("waitrequest", 32'h1, {31'h0, avs_waitrequest});
        check("irq", 32'h0, {31'h0, irq});
        // power-up time read
        for (int i = 2; i < NREG; i++)
        begin
            rtcpi_host_model_i.reg_read(5'(i), rd);
            check("reset time", {24'h0, CLK_RST[i]}, rd);
        end
        // table: write each register, read it back
        for (int i = 0; i < 8; i++)
        begin
            rtcpi_host_model_i.reg_write(row_sel[i], row_val[i],
                                         STROBE_CYC + 2);
            rtcpi_host_model_i.reg_read(row_sel[i], rd);
            check("written", {24'h0, row_val[i]}, rd);
        end
        // strobe too short leaves the register alone
        rtcpi_host_model_i.reg_write(5'h00, 8'h11, 5);
        rtcpi_host_model_i.reg_read(5'h00, rd);
        check("short strobe", {24'h0, row_val[0]}, rd);
        rtcpi_host_model_i.reg_read(5'h09, rd);
        check("no such register", 32'h0, rd);
        rtcpi_host_model_i.bus(1'b0, 10'h000, 32'h0, rd);
        check("unmapped", 32'h0, rd);
        // write done is pending but masked
        check("masked irq", 32'h0, {31'h0, irq});
        rtcpi_host_model_i.bus(1'b1, ADDR_MASK, 32'h1, rd);
        n = 0;
        while (irq !== 1'b1 && n < TICK + 100)
        begin
            n++;
            @(posedge ref_clk);
        end
        check("tick irq", 32'h1, {31'h0, irq});
        rtcpi_host_model_i.bus(1'b0, ADDR_STAT, 32'h0, rd);
        check("status", 32'h3, rd);
        rtcpi_host_model_i.bus(1'b0, ADDR_STAT, 32'h0, rd);
        check("status cleared", 32'h0, rd);
        @(posedge ref_clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        // one second past the end of the year rolls every field
        for (int i = 0; i < 8; i++)
        begin
            rtcpi_host_model_i.reg_read(5'(i), rd);
            check("rollover", {24'h0, (i < 2) ? row_val[i] : CLK_RST[i]},
                  rd);
        end
        // reset in mid-run returns the clock and the bus to idle
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        check("reset waitrequest", 32'h1, {31'h0, avs_waitrequest});
        check("reset irq", 32'h0, {31'h0, irq});
        rtcpi_host_model_i.reg_read(5'h00, rd);
        check("reset storage", {24'h0, CLK_RST[0]}, rd);
        rtcpi_host_model_i.bus(1'b0, ADDR_STAT, 32'h0, rd);
        check("reset status", 32'h0, rd);
        stop_test();
    end
endmodule : rtcpi_tb_top
